//--- core/drive_ref_map.svh
// Register offsets, field positions, reset values and timing for the drive reference block.
// Assumes a 32-bit word register port with byte addresses in 8 bits; frequencies in 0.01 Hz,
// current in 0.01 mA, ramp times in units picked by the ramp time unit field.
//
// Functional notes
// - Current reference is low-pass filtered, constant 0..9999 ms, default 10 ms.
// - Lower scaling point maps minimum current (default 4 mA) to frequency (default 0 Hz).
// - Upper scaling point maps maximum current (default 20 mA) to frequency (default 60 Hz).
// - With PID or outer loop enabled, scaling outputs are user units 0..100.00.
// - Current drives the command only in current-only or voltage plus current mode.
// - Maximum-frequency basis: ramp times span 0 Hz to the top frequency limit.
// - Delta-frequency basis: ramp times span present frequency to target frequency.
// - Three ramp-set bits form a code; 000 base times, 1..7 preset pairs.
// - Base pair defaults 20/30 s; 60.0/90.0 s for high-power units.
// - Ramp time unit: 0 gives 0.01 s, 1 gives 0.1 s (default), 2 gives 1 s.
// - Run source: panel keys, terminals method 1 or 2, or serial link.
// - Dual direction mode: forward pin runs forward, reverse pin runs reverse.
// - Run plus direction mode: forward pin runs, reverse pin picks direction.
// - Run source resets to 1, reference source resets to 0.
// - Staged panel entry: edited setpoint reaches output only on commit key.
// - Live panel entry: up/down change output at once; commit only saves.
// - Voltage plus current mode: voltage reference wins when both are present.
// - Pulse mode: command taken from pulse input, 0..100 kHz.
// - Outer loop mode: loop-run terminal on starts loop; loop output is command.
// - Speed bits pick step frequencies; code zero uses the reference source.
`ifndef DRIVE_REF_MAP_SVH
`define DRIVE_REF_MAP_SVH

`define OFS_REF_SRC 8'h00
`define OFS_RUN_SRC 8'h04
`define OFS_PANEL_SET 8'h08
`define OFS_CONFIG 8'h0C
`define OFS_TOP_LIMIT 8'h10
`define OFS_CUR_FILTER 8'h14
`define OFS_CUR_X1 8'h18
`define OFS_CUR_Y1 8'h1C
`define OFS_CUR_X2 8'h20
`define OFS_CUR_Y2 8'h24
`define OFS_OUT_FREQ 8'h28
`define OFS_TARGET 8'h2C
`define OFS_CUR_FILT 8'h30
`define OFS_STATUS 8'h34
`define OFS_ACCEL_BASE 8'h40
`define OFS_DECEL_BASE 8'h60
`define OFS_STEP_BASE 8'h80

`define CFG_BASIS_BIT 0
`define CFG_UNIT_LSB 1
`define CFG_PID_BIT 3
`define CFG_OUTER_BIT 4

`define RST_REF_SRC 4'h0
`define RST_RUN_SRC 2'h1
`define RST_CONFIG 5'h02
`define RST_TOP_LIMIT 16'h1770
`define RST_CUR_FILTER 14'h000A
`define RST_CUR_X1 12'h190
`define RST_CUR_Y1 16'h0000
`define RST_CUR_X2 12'h7D0
`define RST_CUR_Y2 16'h1770
`define RST_ACC_BASE 16'h00C8
`define RST_DEC_BASE 16'h012C
`define RST_ACC_BIG 16'h0258
`define RST_DEC_BIG 16'h0384
`define RST_TIME_20S 16'h00C8
`define RST_TIME_30S 16'h012C
`define RST_TIME_40S 16'h0190
`define RST_TIME_50S 16'h01F4
`define RST_STEP1 16'h03E8
`define RST_STEP2 16'h07D0
`define RST_STEP3 16'h0BB8
`define USER_UNIT_MAX 16'h2710
`define PULSE_MAX 20'hF4240

`define CLK_PERIOD_NS 20
`define NS_PER_MS 1000000
`define FILTER_TICK_MS 1
`define RAMP_TICK_MS 10

`endif

//--- core/drive_ref_pkg.sv
// Types shared by the drive reference block: source selections and panel entry states.
// Assumes the map header supplies all numeric constants.
package drive_ref_pkg;
    typedef enum logic [3:0] {
        SRC_PANEL_STAGED = 4'h0,
        SRC_PANEL_LIVE = 4'h1,
        SRC_VOLTAGE = 4'h2,
        SRC_VOLTAGE_BIPOLAR = 4'h3,
        SRC_CURRENT = 4'h4,
        SRC_VOLT_PLUS_CUR = 4'h5,
        SRC_PULSE = 4'h6,
        SRC_SERIAL = 4'h7,
        SRC_OUTER_LOOP = 4'h8
    } ref_source_t;

    typedef enum logic [1:0] {
        RUN_PANEL = 2'h0,
        RUN_DUAL_DIRECTION = 2'h1,
        RUN_PLUS_DIRECTION = 2'h2,
        RUN_SERIAL = 2'h3
    } run_source_t;

    typedef enum logic {
        PANEL_IDLE = 1'b0,
        PANEL_EDITING = 1'b1
    } panel_state_t;
endpackage

//--- core/drive_reference_and_ramp_select.sv
// Drive frequency command selection, current reference conditioning, ramp and run decode.
// Assumes terminal and panel inputs synchronous to clk; analog values arrive already digitised.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "drive_ref_map.svh"

module drive_reference_and_ramp_select
    import drive_ref_pkg::*;
#(
    parameter int MS_CYCLES = `NS_PER_MS * `FILTER_TICK_MS / `CLK_PERIOD_NS,
    parameter int RAMP_TICK_CYCLES = `NS_PER_MS * `RAMP_TICK_MS / `CLK_PERIOD_NS,
    parameter bit HIGH_POWER = 1'b0,
    parameter logic [15:0] PANEL_STEP = 16'h0001
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Analog and pulse references, already digitised
    input wire logic [11:0] current_in,
    input wire logic current_present,
    input wire logic [15:0] voltage_ref_pin,
    input wire logic voltage_present,
    input wire logic [19:0] pulse_freq_in,
    input wire logic [15:0] serial_freq_in,
    input wire logic [15:0] outer_loop_out,
    // Multi-function inputs: ramp set, speed bits, loop run
    input wire logic ramp_set_bit0,
    input wire logic ramp_set_bit1,
    input wire logic ramp_set_bit2,
    input wire logic [2:0] speed_bits,
    input wire logic outer_loop_run,
    // Run terminals and serial run
    input wire logic forward_run_pin,
    input wire logic reverse_run_pin,
    input wire logic serial_run,
    input wire logic serial_reverse,
    // Operator panel keys, one-cycle pulses; panel_reverse is a level
    input wire logic edit_key,
    input wire logic commit_key,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic panel_run_key,
    input wire logic panel_stop_key,
    input wire logic panel_reverse,
    // Drive outputs
    output logic [15:0] output_freq,
    output logic [15:0] target_freq,
    output logic run_active,
    output logic reverse_dir,
    output logic [11:0] loop_feedback
);
    // Configuration registers
    ref_source_t reference_source_select;
    run_source_t run_source_select;
    logic [4:0] config_bits;
    logic [15:0] top_frequency_limit;
    logic [13:0] cur_filter_ms;
    logic [11:0] cur_x1, cur_x2;
    logic [15:0] cur_y1, cur_y2;
    logic [15:0] accel_time [8];
    logic [15:0] decel_time [8];
    logic [15:0] step_freq [8];
    // Panel entry
    panel_state_t panel_state;
    logic [15:0] panel_frequency_setpoint, panel_edit;
    logic panel_run;
    // Conditioning and ramp
    logic [11:0] cur_filt;
    logic [31:0] ms_cnt, ramp_cnt;
    logic [23:0] ramp_acc;
    logic [15:0] ramp_start, prev_target;

    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    function automatic logic [15:0] limit(input logic [15:0] v, input logic [15:0] hi);
        return (v > hi) ? hi : v;
    endfunction

    // Register decode
    wire logic wr_ref = wr && addr == `OFS_REF_SRC;
    wire logic wr_run = wr && addr == `OFS_RUN_SRC;
    wire logic wr_panel = wr && addr == `OFS_PANEL_SET;
    wire logic wr_accel = wr && addr[7:5] == 3'(`OFS_ACCEL_BASE >> 5);
    wire logic wr_decel = wr && addr[7:5] == 3'(`OFS_DECEL_BASE >> 5);
    wire logic wr_step = wr && addr[7:5] == 3'(`OFS_STEP_BASE >> 5);
    wire logic [2:0] tbl_idx = addr[4:2];
    wire logic basis_delta = config_bits[`CFG_BASIS_BIT];
    wire logic [1:0] ramp_time_unit = config_bits[`CFG_UNIT_LSB +: 2];
    wire logic user_units = config_bits[`CFG_PID_BIT] | config_bits[`CFG_OUTER_BIT];
    wire logic ms_tick = ms_cnt == 32'(MS_CYCLES - 1);
    wire logic ramp_tick = ramp_cnt == 32'(RAMP_TICK_CYCLES - 1);

    // Read mux; unmapped addresses read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr[7:5])
            3'h2: rd_mux = {16'h0000, accel_time[tbl_idx]};
            3'h3: rd_mux = {16'h0000, decel_time[tbl_idx]};
            3'h4: rd_mux = (tbl_idx == 3'h0) ? 32'h0000_0000 : {16'h0000, step_freq[tbl_idx]};
            default: begin
                case (addr)
                    `OFS_REF_SRC: rd_mux = {28'h0000000, reference_source_select};
                    `OFS_RUN_SRC: rd_mux = {30'h00000000, run_source_select};
                    `OFS_PANEL_SET: rd_mux = {16'h0000, panel_frequency_setpoint};
                    `OFS_CONFIG: rd_mux = {27'h0000000, config_bits};
                    `OFS_TOP_LIMIT: rd_mux = {16'h0000, top_frequency_limit};
                    `OFS_CUR_FILTER: rd_mux = {18'h00000, cur_filter_ms};
                    `OFS_CUR_X1: rd_mux = {20'h00000, cur_x1};
                    `OFS_CUR_Y1: rd_mux = {16'h0000, cur_y1};
                    `OFS_CUR_X2: rd_mux = {20'h00000, cur_x2};
                    `OFS_CUR_Y2: rd_mux = {16'h0000, cur_y2};
                    `OFS_OUT_FREQ: rd_mux = {16'h0000, output_freq};
                    `OFS_TARGET: rd_mux = {16'h0000, target_freq};
                    `OFS_CUR_FILT: rd_mux = {20'h00000, cur_filt};
                    `OFS_STATUS: rd_mux = {29'h00000000, panel_state == PANEL_EDITING, reverse_dir, run_active};
                    default: rd_mux = 32'h0000_0000;
                endcase
            end
        endcase
    end

    always_ff @(posedge clk) begin
        rdata <= srst ? 32'h0000_0000 : (rd ? rd_mux : 32'h0000_0000);
    end

    // Configuration writes; out-of-range sources keep the old value
    always_ff @(posedge clk) begin
        if (srst) begin
            reference_source_select <= ref_source_t'(`RST_REF_SRC);
            run_source_select <= run_source_t'(`RST_RUN_SRC);
            config_bits <= `RST_CONFIG;
            top_frequency_limit <= `RST_TOP_LIMIT;
            cur_filter_ms <= `RST_CUR_FILTER;
            cur_x1 <= `RST_CUR_X1;
            cur_y1 <= `RST_CUR_Y1;
            cur_x2 <= `RST_CUR_X2;
            cur_y2 <= `RST_CUR_Y2;
        end else if (wr) begin
            if (wr_ref && wdata[3:0] <= 4'h8) reference_source_select <= ref_source_t'(wdata[3:0]);
            if (wr_run) run_source_select <= run_source_t'(wdata[1:0]);
            if (addr == `OFS_CONFIG && wdata[2:1] != 2'h3) config_bits <= wdata[4:0];
            if (addr == `OFS_TOP_LIMIT) top_frequency_limit <= wdata[15:0];
            if (addr == `OFS_CUR_FILTER && wdata[13:0] <= 14'h270F) cur_filter_ms <= wdata[13:0];
            if (addr == `OFS_CUR_X1 && wdata[11:0] <= `RST_CUR_X2) cur_x1 <= wdata[11:0];
            if (addr == `OFS_CUR_Y1) cur_y1 <= wdata[15:0];
            if (addr == `OFS_CUR_X2 && wdata[11:0] <= `RST_CUR_X2) cur_x2 <= wdata[11:0];
            if (addr == `OFS_CUR_Y2) cur_y2 <= wdata[15:0];
        end
    end

    // Ramp time pairs and step table; defaults follow the preset pattern
    always_ff @(posedge clk) begin
        if (srst) begin
            accel_time <= '{HIGH_POWER ? `RST_ACC_BIG : `RST_ACC_BASE, `RST_TIME_20S, `RST_TIME_30S,
                `RST_TIME_40S, `RST_TIME_50S, `RST_TIME_40S, `RST_TIME_30S, `RST_TIME_20S};
            decel_time <= '{HIGH_POWER ? `RST_DEC_BIG : `RST_DEC_BASE, `RST_TIME_20S, `RST_TIME_30S,
                `RST_TIME_40S, `RST_TIME_50S, `RST_TIME_40S, `RST_TIME_30S, `RST_TIME_20S};
            step_freq <= '{16'h0000, `RST_STEP1, `RST_STEP2, `RST_STEP3, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        end else begin
            if (wr_accel) accel_time[tbl_idx] <= wdata[15:0];
            if (wr_decel) decel_time[tbl_idx] <= wdata[15:0];
            if (wr_step && tbl_idx != 3'h0) step_freq[tbl_idx] <= wdata[15:0];
        end
    end

    // Panel entry: edit_key opens an edit, up/down adjust, commit saves
    always_ff @(posedge clk) begin
        if (srst) begin
            panel_state <= PANEL_IDLE;
            panel_frequency_setpoint <= 16'h0000;
            panel_edit <= 16'h0000;
        end else begin
            unique case (panel_state)
                PANEL_IDLE: begin
                    if (edit_key) begin
                        panel_state <= PANEL_EDITING;
                        panel_edit <= panel_frequency_setpoint;
                    end
                end
                PANEL_EDITING: begin
                    if (commit_key) begin
                        panel_state <= PANEL_IDLE;
                        panel_frequency_setpoint <= panel_edit;
                    end else if (key_up) begin
                        panel_edit <= limit(panel_edit + PANEL_STEP, top_frequency_limit);
                    end else if (key_down) begin
                        panel_edit <= (panel_edit > PANEL_STEP) ? panel_edit - PANEL_STEP : 16'h0000;
                    end
                end
            endcase
            if (wr_panel) panel_frequency_setpoint <= wdata[15:0];
        end
    end

    // Current filter: first-order step each millisecond, always moves at least one code
    wire logic [11:0] filt_diff = (current_in > cur_filt) ? current_in - cur_filt : cur_filt - current_in;
    wire logic [11:0] filt_q = 12'(filt_diff / (cur_filter_ms + 14'h0001));
    wire logic [11:0] filt_step = (filt_q == 12'h000 && filt_diff != 12'h000) ? 12'h001 : filt_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            ms_cnt <= 32'h0000_0000;
            cur_filt <= 12'h000;
            loop_feedback <= 12'h000;
        end else begin
            ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
            if (ms_tick) begin
                if (cur_filter_ms == 14'h0000) cur_filt <= current_in;
                else cur_filt <= (current_in > cur_filt) ? cur_filt + filt_step : cur_filt - filt_step;
            end
            loop_feedback <= cur_filt;
        end
    end

    // Current scaling: linear between points, clamped outside them
    wire logic [15:0] y1_eff = user_units ? limit(cur_y1, `USER_UNIT_MAX) : limit(cur_y1, top_frequency_limit);
    wire logic [15:0] y2_eff = user_units ? limit(cur_y2, `USER_UNIT_MAX) : limit(cur_y2, top_frequency_limit);
    wire logic [11:0] x_span = cur_x2 - cur_x1;
    wire logic [11:0] x_off = (cur_filt <= cur_x1) ? 12'h000 : ((cur_filt >= cur_x2) ? x_span : cur_filt - cur_x1);
    wire logic [27:0] y_prod = 28'(x_off) * 28'(abs_diff(y2_eff, y1_eff));
    wire logic [15:0] y_delta = (x_span == 12'h000) ? 16'h0000 : 16'(y_prod / 28'(x_span));
    wire logic [15:0] current_freq = (y2_eff >= y1_eff) ? y1_eff + y_delta : y1_eff - y_delta;

    // Reference source selection
    logic [15:0] source_freq;
    always_comb begin
        source_freq = 16'h0000;
        unique case (reference_source_select)
            SRC_PANEL_STAGED: source_freq = panel_frequency_setpoint;
            SRC_PANEL_LIVE: source_freq = (panel_state == PANEL_EDITING) ? panel_edit : panel_frequency_setpoint;
            SRC_VOLTAGE, SRC_VOLTAGE_BIPOLAR: source_freq = voltage_ref_pin;
            SRC_CURRENT: source_freq = current_freq;
            SRC_VOLT_PLUS_CUR: source_freq = voltage_present ? voltage_ref_pin : current_freq;
            SRC_PULSE: source_freq = 16'(limit(16'(pulse_freq_in / 20'h00064), 16'hFFFF));
            SRC_SERIAL: source_freq = serial_freq_in;
            SRC_OUTER_LOOP: source_freq = outer_loop_run ? outer_loop_out : 16'h0000;
            default: source_freq = 16'h0000;
        endcase
    end

    wire logic [15:0] speed_freq = (speed_bits == 3'h0) ? source_freq : step_freq[speed_bits];
    wire logic [15:0] next_target = run_active ? limit(speed_freq, top_frequency_limit) : 16'h0000;

    // Run decode
    logic next_run, next_rev;
    always_comb begin
        next_run = 1'b0;
        next_rev = reverse_dir;
        unique case (run_source_select)
            RUN_PANEL: begin
                next_run = panel_run;
                next_rev = panel_reverse;
            end
            RUN_DUAL_DIRECTION: begin
                next_run = forward_run_pin ^ reverse_run_pin;
                next_rev = (forward_run_pin ^ reverse_run_pin) ? reverse_run_pin : reverse_dir;
            end
            RUN_PLUS_DIRECTION: begin
                next_run = forward_run_pin;
                next_rev = reverse_run_pin;
            end
            RUN_SERIAL: begin
                next_run = serial_run;
                next_rev = serial_reverse;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            panel_run <= 1'b0;
            run_active <= 1'b0;
            reverse_dir <= 1'b0;
            target_freq <= 16'h0000;
        end else begin
            panel_run <= panel_stop_key ? 1'b0 : (panel_run_key ? 1'b1 : panel_run);
            run_active <= next_run;
            reverse_dir <= next_rev;
            target_freq <= next_target;
        end
    end

    // Ramp: Bresenham spread of the span over the selected time, in 10 ms ticks
    wire logic [2:0] sel_code = {ramp_set_bit2, ramp_set_bit1, ramp_set_bit0};
    wire logic accelerating = target_freq > output_freq;
    wire logic [15:0] sel_time = accelerating ? accel_time[sel_code] : decel_time[sel_code];
    wire logic [6:0] unit_mult = (ramp_time_unit == 2'h0) ? 7'd1 : ((ramp_time_unit == 2'h1) ? 7'd10 : 7'd100);
    wire logic [23:0] ramp_ticks = 24'(sel_time) * 24'(unit_mult);
    wire logic [15:0] ramp_span = basis_delta ? abs_diff(target_freq, ramp_start) : top_frequency_limit;
    wire logic [23:0] ramp_sum = ramp_acc + 24'(ramp_span);
    wire logic [23:0] ramp_q = (ramp_ticks == 24'h000000) ? 24'hFFFFFF : ramp_sum / ramp_ticks;
    wire logic [15:0] ramp_gap = abs_diff(target_freq, output_freq);
    wire logic [15:0] ramp_step = (ramp_q > 24'(ramp_gap)) ? ramp_gap : ramp_q[15:0];
    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_cnt <= 32'h0000_0000;
            ramp_acc <= 24'h000000;
            ramp_start <= 16'h0000;
            prev_target <= 16'h0000;
            output_freq <= 16'h0000;
        end else begin
            ramp_cnt <= ramp_tick ? 32'h0000_0000 : ramp_cnt + 32'h0000_0001;
            prev_target <= target_freq;
            if (target_freq != prev_target) begin
                ramp_start <= output_freq;
                ramp_acc <= 24'h000000;
            end else if (ramp_tick && ramp_gap != 16'h0000) begin
                ramp_acc <= (ramp_ticks == 24'h000000) ? 24'h000000 : ramp_sum % ramp_ticks;
                output_freq <= accelerating ? output_freq + ramp_step : output_freq - ramp_step;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_read_req;
        rd && addr == `OFS_RUN_SRC;
    endsequence
    sequence s_run_word;
        rdata == {30'h00000000, run_source_select};
    endsequence
    property p_read_run_src;
        s_read_req |=> s_run_word;
    endproperty
    a_read_run_src: assert property (p_read_run_src) else $error("run source read mismatch");

    property p_dual_dir;
        run_source_select == RUN_DUAL_DIRECTION && forward_run_pin && !reverse_run_pin
            && !wr_run |=> run_active && !reverse_dir;
    endproperty
    a_dual_dir: assert property (p_dual_dir) else $error("forward terminal did not run forward");

    property p_run_plus_dir;
        run_source_select == RUN_PLUS_DIRECTION && !wr_run |=> reverse_dir == $past(reverse_run_pin)
            && run_active == $past(forward_run_pin);
    endproperty
    a_run_plus_dir: assert property (p_run_plus_dir) else $error("run plus direction decode wrong");

    property p_staged_hold;
        reference_source_select == SRC_PANEL_STAGED && panel_state == PANEL_EDITING && !commit_key
            && !wr_panel |=> $stable(panel_frequency_setpoint);
    endproperty
    a_staged_hold: assert property (p_staged_hold) else $error("setpoint changed before commit");

    property p_live_follow;
        reference_source_select == SRC_PANEL_LIVE && panel_state == PANEL_EDITING && run_active
            && speed_bits == 3'h0 && panel_edit <= top_frequency_limit |=> target_freq == $past(panel_edit);
    endproperty
    a_live_follow: assert property (p_live_follow) else $error("live entry not applied");

    property p_volt_priority;
        reference_source_select == SRC_VOLT_PLUS_CUR && voltage_present && run_active && speed_bits == 3'h0
            && voltage_ref_pin <= top_frequency_limit |=> target_freq == $past(voltage_ref_pin);
    endproperty
    a_volt_priority: assert property (p_volt_priority) else $error("voltage did not override current");

    property p_clamp;
        cur_filt <= cur_x1 && cur_x1 < cur_x2 |-> current_freq == y1_eff;
    endproperty
    a_clamp: assert property (p_clamp) else $error("below lower point not clamped");

    sequence s_stopped;
        !run_active ##1 !run_active;
    endsequence
    property p_stop_target;
        s_stopped |=> target_freq == 16'h0000;
    endproperty
    a_stop_target: assert property (p_stop_target) else $error("target not zero while stopped");

    property p_ramp_toward;
        ramp_tick && target_freq == prev_target && target_freq > output_freq
            |=> output_freq <= $past(target_freq) && output_freq >= $past(output_freq);
    endproperty
    a_ramp_toward: assert property (p_ramp_toward) else $error("ramp moved away from target");
endmodule // drive_reference_and_ramp_select

//--- bench/drive_sources.sv
// Model of the analog sources and run terminals that feed the drive.
// Assumes the bench sets the wanted levels; lines change just after clk rises.
`timescale 1ns/10ps
module drive_sources (
    // Clock
    input wire logic clk,
    // Wanted levels
    input wire logic [11:0] cur_set,
    input wire logic [15:0] volt_set,
    input wire logic volt_on,
    input wire logic [1:0] run_set,
    // Lines into the drive
    output logic [11:0] current_in,
    output logic [15:0] voltage_ref_pin,
    output logic voltage_present,
    output logic forward_run_pin,
    output logic reverse_run_pin
);
    // An absent voltage source shows a changing pattern, so a stale value is never trusted
    always_ff @(posedge clk) begin
        current_in <= cur_set;
        voltage_present <= volt_on;
        voltage_ref_pin <= volt_on ? volt_set : ~voltage_ref_pin;
        {reverse_run_pin, forward_run_pin} <= run_set;
    end
endmodule // drive_sources

//--- bench/tb.sv
// Self-checking bench for the drive reference block.
// Assumes the source model in drive_sources.sv; short tick parameters keep the run brief.
`timescale 1ns/10ps
module tb;
    logic clk = 0, srst = 1, wr = 0, rd = 0, volt_on = 0, current_present = 1;
    logic edit_key = 0, commit_key = 0, key_up = 0, key_down = 0, panel_run_key = 0;
    logic panel_stop_key = 0, panel_reverse = 0, serial_run = 0, serial_reverse = 0, outer_loop_run = 0;
    logic ramp_set_bit0 = 0, ramp_set_bit1 = 0, ramp_set_bit2 = 0, voltage_present, forward_run_pin;
    logic reverse_run_pin, run_active, reverse_dir;
    logic [2:0] speed_bits = 3'h0;
    logic [1:0] run_set = 2'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [11:0] cur_set = 12'h000, current_in, loop_feedback;
    logic [19:0] pulse_freq_in = 20'h00000;
    logic [15:0] volt_set = 16'h0000, serial_freq_in = 16'h0000, outer_loop_out = 16'h0000;
    logic [15:0] voltage_ref_pin, output_freq, target_freq, o;
    int n_fail = 0, checks_done = 0, cyc = 0;

    drive_reference_and_ramp_select #(.MS_CYCLES(4), .RAMP_TICK_CYCLES(10)) u_drive_reference_and_ramp_select (.*);
    drive_sources u_drive_sources (.*);

    // Clock and hang guard
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            n_fail++;
            $display("ERROR %0t: timeout", $time);
            finish_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle strobes; read data is taken in the single cycle it stands
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Panel keys as one-cycle pulses: {edit, commit, up, down}
    task automatic key(input logic [3:0] k);
        @(posedge clk);
        {edit_key, commit_key, key_up, key_down} <= k;
        @(posedge clk);
        {edit_key, commit_key, key_up, key_down} <= 4'h0;
    endtask
    task automatic finish_test();
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rchk(8'h00, 32'h0);
        rchk(8'h04, 32'h1);
        rchk(8'h0C, 32'h2);
        rchk(8'h14, 32'd10);
        rchk(8'h18, 32'd400);
        rchk(8'h1C, 32'd0);
        rchk(8'h20, 32'd2000);
        rchk(8'h24, 32'd6000);
        rchk(8'h40, 32'd200);
        rchk(8'h60, 32'd300);
        rchk(8'hFC, 32'h0);
        run_set <= 2'b01;
        step(4);
        chk({run_active, reverse_dir}, 2'b10);
        run_set <= 2'b10;
        step(4);
        chk({run_active, reverse_dir}, 2'b11);
        run_set <= 2'b11;
        step(4);
        chk(run_active, 1'b0);
        wreg(8'h04, 32'h2);
        step(4);
        chk({run_active, reverse_dir}, 2'b11);
        run_set <= 2'b01;
        step(4);
        chk({run_active, reverse_dir}, 2'b10);
        wreg(8'h14, 32'h0);
        wreg(8'h00, 32'h4);
        cur_set <= 12'd1200;
        step(30);
        chk(target_freq, 16'd3000);
        wreg(8'h20, 32'd1600);
        cur_set <= 12'd1900;
        step(30);
        chk(target_freq, 16'd6000);
        chk(loop_feedback, 32'd1900);
        wreg(8'h00, 32'h5);
        volt_on <= 1'b1;
        volt_set <= 16'd1234;
        step(10);
        chk(target_freq, 16'd1234);
        wreg(8'h00, 32'h6);
        pulse_freq_in <= 20'd50000;
        step(10);
        chk(target_freq, 16'd500);
        wreg(8'h0C, 32'h0);
        wreg(8'h40, 32'd60);
        volt_set <= 16'd6000;
        wreg(8'h00, 32'h2);
        o = output_freq;
        for (int i = 0; i < 40 && output_freq === o; i++) step(1);
        o = output_freq;
        step(10);
        chk(output_freq - o, 16'd100);
        // Staged entry holds the output until commit, live entry applies at once
        wreg(8'h08, 32'd1000);
        wreg(8'h00, 32'h0);
        key(4'h8);
        key(4'h2);
        step(3);
        chk(target_freq, 16'd1000);
        key(4'h4);
        step(3);
        chk(target_freq, 16'd1001);
        wreg(8'h00, 32'h1);
        key(4'h8);
        key(4'h2);
        step(3);
        chk(target_freq, 16'd1002);
        rchk(8'h08, 32'd1001);
        key(4'h4);
        rchk(8'h08, 32'd1002);
        speed_bits <= 3'h2;
        step(3);
        chk(target_freq, 16'd2000);
        speed_bits <= 3'h0;
        wreg(8'h00, 32'h8);
        outer_loop_out <= 16'd2500;
        outer_loop_run <= 1'b1;
        step(3);
        chk(target_freq, 16'd2500);
        wreg(8'h04, 32'h3);
        {serial_run, serial_reverse} <= 2'b11;
        step(3);
        chk({run_active, reverse_dir}, 2'b11);
        finish_test();
    end
endmodule // tb
